// ===== rtl/pfs_snapshot.sv
// permanent-failure snapshot logger with an AHB-Lite register slave
// assumes: fault flags, measurements and front-end copies come from logic on ref_clk
`timescale 1ns/1ps
`include "pfs_cfg.svh"
// Contract
// - failure flag enabled in the blow-enable register sets fuse request 0x3672
// - no failure flag means fuse reads 0x0000
// - clear command returns fuse to 0x0000, unless an enabled failure flag arrives in the same cycle
// - first failure captures pack voltage
// - first failure captures all four cell voltages
// - first failure captures pack current
// - first failure captures temperature
// - first failure captures battery status
// - first failure captures capacity in both units
// - first failure captures charging status
// - first failure captures safety status
// - later failures do not overwrite snapshots until a clear command
// - first-failure record holds exactly one cause
// - first-failure record keeps earliest cause
// - first failure captures front-end images
// - front-end snapshots read zero before failure
// - front-end snapshots come from working copies
// - cumulative flags accumulate every cause
// - enabled fuse-blow cause writes fuse code
module pfs_snapshot
    import pfs_pkg::*;
#(
    parameter int FLAG_W = 16
) (
    input  wire logic              ref_clk,    // 250 MHz
    input  wire logic              rst_n,      // sync reset
    input  wire logic              clkEn,      // freezes all state when low
    input  wire logic [FLAG_W-1:0] faultFlags, // one pulse bit per cause
    input  wire pfs_meas_t         meas,       // live measurements
    input  wire pfs_afe_t          afe,        // front-end working copies
    input  wire logic              hsel,       // AHB select
    input  wire logic [7:0]        haddr,      // AHB address
    input  wire logic [1:0]        htrans,     // AHB transfer type
    input  wire logic              hwrite,     // AHB write
    input  wire logic [2:0]        hsize,      // AHB size
    input  wire logic [31:0]       hwdata,     // AHB write data
    input  wire logic              hready,     // AHB bus ready
    output logic [31:0]            hrdata,     // AHB read data
    output logic                   hreadyout,  // always ready
    output logic                   hresp,      // always OKAY
    output logic                   fuseBlow    // fuse request active
);
    // ****************************************
    // elaboration checks
    // ****************************************
    if (FLAG_W < 1 || FLAG_W > 16) begin : g_chk
        $error("FLAG_W must be 1..16");
    end

    // ****************************************
    // state
    // ****************************************
    logic [15:0]       fuseCode_reg;
    logic              captured_reg;
    pfs_meas_t         measSnap_reg;
    pfs_afe_t          afeSnap_reg;
    logic [FLAG_W-1:0] firstRec_reg;
    logic [FLAG_W-1:0] cumul_reg;
    logic [FLAG_W-1:0] blowEn_reg;
    logic              wrPend_reg;
    logic [7:0]        wrAddr_reg;
    logic [7:0]        rdAddr_next;
    logic [FLAG_W-1:0] firstOne;
    logic              anyFault;
    logic              clearCmd;
    logic              addrPhase;
    logic [15:0]       measWord [12];
    logic [7:0]        afeWord  [9];

    assign anyFault  = |faultFlags;
    assign addrPhase = hsel && hready && htrans == `PFS_HTRANS_NONSEQ;
    assign clearCmd  = wrPend_reg && wrAddr_reg == `PFS_OFF_CMD && hwdata[15:0] == `PFS_CLEAR_KEY;
    assign firstOne  = faultFlags & (~faultFlags + 1'b1); // lowest cause wins a tie

    // ****************************************
    // bus write path: data phase follows address
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
        end else if (clkEn) begin
            wrPend_reg <= addrPhase && hwrite;
            wrAddr_reg <= haddr;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            blowEn_reg <= '0;
        end else if (clkEn && wrPend_reg && wrAddr_reg == `PFS_OFF_BLOWEN) begin
            blowEn_reg <= hwdata[FLAG_W-1:0];
        end
    end

    // ****************************************
    // fuse request and capture latch
    // ****************************************
    // a new fault in the clear cycle wins (for the fuse code only an enabled one), so no cause is dropped
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fuseCode_reg <= `PFS_FUSE_IDLE;
        end else if (clkEn) begin
            if (|(faultFlags & blowEn_reg)) begin
                fuseCode_reg <= `PFS_FUSE_CODE;
            end else if (clearCmd) begin
                fuseCode_reg <= `PFS_FUSE_IDLE;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            captured_reg <= 1'b0;
        end else if (clkEn) begin
            if (anyFault) begin
                captured_reg <= 1'b1;
            end else if (clearCmd) begin
                captured_reg <= 1'b0;
            end
        end
    end

    // ****************************************
    // snapshots
    // ****************************************
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            measSnap_reg <= '0;
            afeSnap_reg  <= '0;
        end else if (clkEn && anyFault && !captured_reg) begin
            measSnap_reg <= meas;
            afeSnap_reg  <= afe;
        end
    end

    // first record survives the clear command, only reset wipes it
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            firstRec_reg <= '0;
        end else if (clkEn && anyFault && firstRec_reg == '0) begin
            firstRec_reg <= firstOne;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cumul_reg <= '0;
        end else if (clkEn) begin
            if (clearCmd) begin
                cumul_reg <= faultFlags; // set wins over clear
            end else begin
                cumul_reg <= cumul_reg | faultFlags;
            end
        end
    end

    // ****************************************
    // read mux
    // ****************************************
    // slices come straight off the flops, so reads always follow the snapshot
    logic [191:0] flatMeas;
    assign flatMeas = measSnap_reg;

    genvar gm;
    for (gm = 0; gm < 12; gm++) begin : g_meas
        assign measWord[gm] = flatMeas[191 - 16*gm -: 16];
    end

    genvar gi;
    for (gi = 0; gi < 9; gi++) begin : g_afe
        logic [71:0] flatAfe;
        assign flatAfe     = afeSnap_reg;
        assign afeWord[gi] = flatAfe[71 - 8*gi -: 8];
    end

    assign rdAddr_next = haddr;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hrdata <= 32'h0000_0000;
        end else if (clkEn && addrPhase && !hwrite) begin
            hrdata <= 32'h0000_0000;
            if (rdAddr_next >= `PFS_OFF_CELL0 && rdAddr_next < `PFS_OFF_CURR) begin
                // cells are packed highest first, lowest cell sits at the lowest offset
                hrdata <= {16'h0000, measWord[4 - int'((rdAddr_next - `PFS_OFF_CELL0) >> 2)]};
            end else if (rdAddr_next >= `PFS_OFF_FEN0 && rdAddr_next < `PFS_OFF_BLOWEN) begin
                hrdata <= {24'h000000, afeWord[4'((rdAddr_next - `PFS_OFF_FEN0) >> 2)]};
            end else begin
                unique case (rdAddr_next)
                    `PFS_OFF_FUSE:   hrdata <= {16'h0000, fuseCode_reg};
                    `PFS_OFF_PACKV:  hrdata <= {16'h0000, measWord[0]};
                    `PFS_OFF_CURR:   hrdata <= {16'h0000, measWord[5]};
                    `PFS_OFF_TEMP:   hrdata <= {16'h0000, measWord[6]};
                    `PFS_OFF_BATST:  hrdata <= {16'h0000, measWord[7]};
                    `PFS_OFF_CAPQ:   hrdata <= {16'h0000, measWord[8]};
                    `PFS_OFF_CAPE:   hrdata <= {16'h0000, measWord[9]};
                    `PFS_OFF_CHGST:  hrdata <= {16'h0000, measWord[10]};
                    `PFS_OFF_SAFST:  hrdata <= {16'h0000, measWord[11]};
                    `PFS_OFF_FIRST:  hrdata <= 32'(firstRec_reg);
                    `PFS_OFF_CUMUL:  hrdata <= 32'(cumul_reg);
                    `PFS_OFF_BLOWEN: hrdata <= 32'(blowEn_reg);
                    `PFS_OFF_STATUS: hrdata <= 32'(captured_reg);
                    default:         hrdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign fuseBlow  = fuseCode_reg == `PFS_FUSE_CODE;

    // ****************************************
    // checks
    // ****************************************
    fuse_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && |(faultFlags & blowEn_reg) |=> fuseCode_reg == `PFS_FUSE_CODE)
        else $error("fuse code not set after enabled fault");
    fuse_values_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        fuseCode_reg == `PFS_FUSE_IDLE || fuseCode_reg == `PFS_FUSE_CODE)
        else $error("fuse code holds an illegal value");
    fuse_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && clearCmd && !anyFault |=> fuseCode_reg == `PFS_FUSE_IDLE)
        else $error("clear did not reset fuse code");
    snap_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && anyFault && !captured_reg |=> measSnap_reg == $past(meas) && captured_reg)
        else $error("snapshot missed first failure");
    snap_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        captured_reg && !clearCmd |=> $stable(measSnap_reg) && $stable(afeSnap_reg))
        else $error("snapshot overwritten");
    afe_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !captured_reg && firstRec_reg == '0 |-> afeSnap_reg == '0)
        else $error("front-end snapshot nonzero before failure");
    first_one_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $onehot0(firstRec_reg))
        else $error("first record holds several causes");
    first_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        firstRec_reg != '0 |=> $stable(firstRec_reg))
        else $error("first record changed");
    cumul_acc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && !clearCmd |=> (cumul_reg & $past(cumul_reg | faultFlags)) == $past(cumul_reg | faultFlags))
        else $error("cumulative flags lost a cause");

    // ****************************************
    // capture checks per field
    // ****************************************
    cells_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && anyFault && !captured_reg |=> measSnap_reg.cellVoltage0 == $past(meas.cellVoltage0)
            && measSnap_reg.cellVoltage1 == $past(meas.cellVoltage1)
            && measSnap_reg.cellVoltage2 == $past(meas.cellVoltage2)
            && measSnap_reg.cellVoltage3 == $past(meas.cellVoltage3))
        else $error("cell snapshot missed first failure");
    curr_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && anyFault && !captured_reg |=> measSnap_reg.packCurrent == $past(meas.packCurrent))
        else $error("current snapshot missed first failure");
    temp_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && anyFault && !captured_reg |=> measSnap_reg.temperature == $past(meas.temperature))
        else $error("temperature snapshot missed first failure");
    batt_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && anyFault && !captured_reg |=> measSnap_reg.batteryStatus == $past(meas.batteryStatus))
        else $error("battery status snapshot missed first failure");
    cap_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && anyFault && !captured_reg |=> measSnap_reg.capacityCharge == $past(meas.capacityCharge)
            && measSnap_reg.capacityEnergy == $past(meas.capacityEnergy))
        else $error("capacity snapshot missed first failure");
    chg_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && anyFault && !captured_reg |=> measSnap_reg.chargingStatus == $past(meas.chargingStatus))
        else $error("charging status snapshot missed first failure");
    safe_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && anyFault && !captured_reg |=> measSnap_reg.safetyStatus == $past(meas.safetyStatus))
        else $error("safety status snapshot missed first failure");
    afe_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && anyFault && !captured_reg |=> afeSnap_reg == $past(afe))
        else $error("front-end snapshot missed first failure");

    // ****************************************
    // latch and record checks
    // ****************************************
    latch_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && anyFault |=> captured_reg)
        else $error("capture latch not set by failure");
    latch_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        captured_reg && !clearCmd |=> captured_reg)
        else $error("capture latch released without clear");
    first_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        clkEn && anyFault && firstRec_reg == '0 |=> (firstRec_reg & $past(faultFlags)) != '0)
        else $error("first record missed earliest cause");
endmodule

// ===== common/pfs_cfg.svh
// register map, codes and field positions of the failure snapshot logger
// assumes: included by the package and the design file, 32-bit AHB-Lite data
`ifndef PFS_CFG_SVH
`define PFS_CFG_SVH
// ****************************************
// codes
// ****************************************
`define PFS_FUSE_CODE       16'h3672
`define PFS_FUSE_IDLE       16'h0000
`define PFS_CLEAR_KEY       16'h5a5a
// ****************************************
// byte offsets
// ****************************************
`define PFS_OFF_FUSE        8'h00
`define PFS_OFF_PACKV       8'h04
`define PFS_OFF_CELL0       8'h08
`define PFS_OFF_CURR        8'h18
`define PFS_OFF_TEMP        8'h1c
`define PFS_OFF_BATST       8'h20
`define PFS_OFF_CAPQ        8'h24
`define PFS_OFF_CAPE        8'h28
`define PFS_OFF_CHGST       8'h2c
`define PFS_OFF_SAFST       8'h30
`define PFS_OFF_FIRST       8'h34
`define PFS_OFF_CUMUL       8'h38
`define PFS_OFF_FEN0        8'h40
`define PFS_OFF_BLOWEN      8'h64
`define PFS_OFF_CMD         8'h68
`define PFS_OFF_STATUS      8'h6c
`define PFS_OFF_TOP         8'h70
// ****************************************
// fields
// ****************************************
`define PFS_ST_LATCH        0
`define PFS_HTRANS_NONSEQ   2'h2
`define PFS_HSIZE_WORD      3'h2
`endif

// ===== common/pfs_pkg.sv
// types shared by the failure snapshot logger
// assumes: pfs_cfg.svh on the include path
`include "pfs_cfg.svh"
package pfs_pkg;
    // live measurements presented by the gauge core
    typedef struct packed {
        logic [15:0] packVoltage;
        logic [15:0] cellVoltage3;
        logic [15:0] cellVoltage2;
        logic [15:0] cellVoltage1;
        logic [15:0] cellVoltage0;
        logic [15:0] packCurrent;
        logic [15:0] temperature;
        logic [15:0] batteryStatus;
        logic [15:0] capacityCharge;
        logic [15:0] capacityEnergy;
        logic [15:0] chargingStatus;
        logic [15:0] safetyStatus;
    } pfs_meas_t;
    // working copies of the nine analog front-end registers
    typedef struct packed {
        logic [7:0] frontendStatus;
        logic [7:0] frontendOutput;
        logic [7:0] frontendState;
        logic [7:0] frontendFunction;
        logic [7:0] frontendCellSelect;
        logic [7:0] overloadThreshold;
        logic [7:0] overloadDelay;
        logic [7:0] shortCircuitCharge;
        logic [7:0] shortCircuitDischarge;
    } pfs_afe_t;
endpackage

// ===== sim/pfs_fault_src.sv
// far-side model: fault detectors and gauge core feeding the logger
// assumes: the bench steers causeIn and base on ref_clk
`timescale 1ns/1ps
module pfs_fault_src
    import pfs_pkg::*;
(
    input  wire logic        ref_clk,    // bench clock
    input  wire logic        rst_n,      // sync reset
    input  wire logic [15:0] causeIn,    // cause bits to raise
    input  wire logic [15:0] base,       // pattern seed
    output logic [15:0]      faultFlags, // cause pulses
    output pfs_meas_t        meas,       // live measurements
    output pfs_afe_t         afe         // front-end copies
);
    logic [7:0] b;
    always_ff @(posedge ref_clk) begin
        faultFlags <= rst_n ? causeIn : 16'h0000;
    end
    // field read at byte 4*(k+1) carries base+k, so a stale capture shows
    assign meas = {base, base + 16'h4, base + 16'h3, base + 16'h2, base + 16'h1,
                   base + 16'h5, base + 16'h6, base + 16'h7, base + 16'h8,
                   base + 16'h9, base + 16'ha, base + 16'hb};
    assign b = base[7:0];
    assign afe = {b, b + 8'h1, b + 8'h2, b + 8'h3, b + 8'h4,
                  b + 8'h5, b + 8'h6, b + 8'h7, b + 8'h8};
endmodule

// ===== sim/permanent_fail_snapshot_tb_top.sv
// bench: AHB-Lite register tests of the failure snapshot logger
// assumes: single slave, hreadyout fed back as hready
`timescale 1ns/1ps
`include "pfs_cfg.svh"
module permanent_fail_snapshot_tb_top;
    import pfs_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] causeIn = 16'h0000;
    logic [15:0] base = 16'h1210;
    logic        hsel = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = `PFS_HSIZE_WORD;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        fuseBlow;
    logic [15:0] faultFlags;
    pfs_meas_t   meas;
    pfs_afe_t    afe;
    int          n_fail = 0;
    int          checks_done = 0;
    logic [31:0] dummy;
    always #2 ref_clk = ~ref_clk;
    pfs_fault_src u_pfs_fault_src (.ref_clk(ref_clk), .rst_n(rst_n), .causeIn(causeIn), .base(base),
        .faultFlags(faultFlags), .meas(meas), .afe(afe));
    pfs_snapshot u_pfs_snapshot (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(1'b1),
        .faultFlags(faultFlags), .meas(meas), .afe(afe), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .fuseBlow(fuseBlow));
    // ****************************************
    // tasks
    // ****************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wait_rdy();
        int i;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            $display("mismatch t=%0t ready never came", $time);
            report_and_stop();
        end
    endtask
    task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                        output logic [31:0] rd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= `PFS_HTRANS_NONSEQ;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        cmp({31'h0, hresp}, 32'h0);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        xfer(a, 1'b0, 32'h0, d);
        cmp(d, exp);
    endtask
    // one-cycle cause pulse, then let capture settle
    task automatic fire(input logic [15:0] c, input logic [15:0] b);
        @(posedge ref_clk);
        causeIn <= c;
        @(posedge ref_clk);
        causeIn <= 16'h0000;
        repeat (3) @(posedge ref_clk);
        base <= b;
    endtask
    task automatic chk_snap(input logic [15:0] b);
        for (int k = 0; k < 12; k++) rd_chk(8'(4 + 4 * k), {16'h0, b + 16'(k)});
        for (int j = 0; j < 9; j++) rd_chk(8'('h40 + 4 * j), {24'h0, b[7:0] + 8'(j)});
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 'h70; a += 4) rd_chk(8'(a), 32'h0);
        xfer(`PFS_OFF_FUSE, 1'b1, 32'h0000ffff, dummy);
        rd_chk(`PFS_OFF_FUSE, 32'h0);
        xfer(`PFS_OFF_BLOWEN, 1'b1, 32'h00000003, dummy);
        rd_chk(`PFS_OFF_BLOWEN, 32'h3);
        $display("test 1 done");
        fire(16'h0010, 16'h2320);
        rd_chk(`PFS_OFF_FUSE, 32'h0);
        chk_snap(16'h1210);
        rd_chk(`PFS_OFF_FIRST, 32'h10);
        rd_chk(`PFS_OFF_CUMUL, 32'h10);
        rd_chk(`PFS_OFF_STATUS, 32'h1);
        $display("test 2 done");
        fire(16'h0006, 16'h3430);
        rd_chk(`PFS_OFF_FUSE, {16'h0, `PFS_FUSE_CODE});
        cmp({31'h0, fuseBlow}, 32'h1);
        chk_snap(16'h1210);
        rd_chk(`PFS_OFF_FIRST, 32'h10);
        rd_chk(`PFS_OFF_CUMUL, 32'h16);
        $display("test 3 done");
        xfer(`PFS_OFF_CMD, 1'b1, {16'h0, `PFS_CLEAR_KEY}, dummy);
        rd_chk(`PFS_OFF_FUSE, 32'h0);
        cmp({31'h0, fuseBlow}, 32'h0);
        rd_chk(`PFS_OFF_STATUS, 32'h0);
        rd_chk(`PFS_OFF_FIRST, 32'h10);
        rd_chk(`PFS_OFF_CUMUL, 32'h0);
        chk_snap(16'h1210);
        $display("test 4 done");
        fire(16'h0001, 16'h1210);
        chk_snap(16'h3430);
        rd_chk(`PFS_OFF_FUSE, {16'h0, `PFS_FUSE_CODE});
        rd_chk(`PFS_OFF_FIRST, 32'h10);
        rd_chk(`PFS_OFF_STATUS, 32'h1);
        $display("test 5 done");
        report_and_stop();
    end
endmodule
